// ### core/adcrt_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCRT_REGS_SVH
`define ADCRT_REGS_SVH
`define ADCRT_ADDR_W 16
`define ADCRT_OFF_RESULT_LO 16'hFF08
`define ADCRT_OFF_RESULT_HI 16'hFF09
`define ADCRT_OFF_MODE 16'hFF28
`define ADCRT_OFF_CHAN 16'hFF29
`define ADCRT_OFF_CMP_MODE 16'hFF2A
`define ADCRT_OFF_THRESH 16'hFF2B
`define ADCRT_RST_CHAN 8'h00
`define ADCRT_RST_CMP_MODE 8'h00
`define ADCRT_RST_THRESH 8'h00
`define ADCRT_RST_MODE 8'h00
`define ADCRT_CHAN_MASK 8'h07
`define ADCRT_CMP_MODE_MASK 8'hC0
`define ADCRT_MODE_MASK 8'hBD
`define ADCRT_BIT_CMP_EN 7
`define ADCRT_BIT_CMP_POL 6
`define ADCRT_BIT_RUN 7
`define ADCRT_RES_W 10
`define ADCRT_RES_PAD 6
`define ADCRT_SAMPLE_CYC 4
`define ADCRT_BIT_CYC 2
`endif

// ### core/adcrt_pkg.sv
// Types shared by the converter control block
package adcrt_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_idx;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic word;
	} adcrt_cpu_req_t;
	typedef struct packed {
		logic done;
		logic [9:0] value;
	} adcrt_conv_t;
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcrt_state_t;
endpackage : adcrt_pkg

// ### core/adcrt_sar.sv
// Successive approximation sequencer, bit 9 first
`timescale 1ns/1ps
`include "adcrt_regs.svh"
module adcrt_sar #(
	parameter int RES_W = `ADCRT_RES_W
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Control
	input wire logic run_in,
	input wire logic restart_in,
	input wire logic cmp_hi_in,
	// Result
	output adcrt_pkg::adcrt_conv_t conv_out,
	output logic [RES_W-1:0] trial_out,
	output logic hold_out
);
	// Refuse result widths the bit sequencing cannot serve
	if (RES_W != 10) begin : g_bad_res_w
		$error("adcrt_sar: RES_W must be 10");
	end
	adcrt_pkg::adcrt_state_t state_q;
	logic [RES_W-1:0] sar_q;
	logic [RES_W-1:0] mask_q;
	logic [7:0] cnt_q;
	wire logic step = (cnt_q == 8'h00);
	wire logic [RES_W-1:0] kept = cmp_hi_in ? sar_q : (sar_q & ~mask_q);
	assign trial_out = sar_q;
	assign hold_out = (state_q == adcrt_pkg::ST_CONVERT);
	// Sample, then resolve one bit per step from the MSB down
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= adcrt_pkg::ST_IDLE;
			sar_q <= '0;
			mask_q <= '0;
			cnt_q <= 8'h00;
			conv_out <= '0;
		end else if (ce_in) begin
			conv_out.done <= 1'b0;
			if (!run_in || restart_in) begin
				state_q <= run_in ? adcrt_pkg::ST_SAMPLE : adcrt_pkg::ST_IDLE;
				cnt_q <= 8'(`ADCRT_SAMPLE_CYC - 1);
			end else begin
				case (state_q)
				adcrt_pkg::ST_IDLE: begin
					state_q <= adcrt_pkg::ST_SAMPLE;
					cnt_q <= 8'(`ADCRT_SAMPLE_CYC - 1);
				end
				adcrt_pkg::ST_SAMPLE: begin
					cnt_q <= cnt_q - 8'h01;
					if (step) begin
						state_q <= adcrt_pkg::ST_CONVERT;
						mask_q <= {1'b1, {(RES_W-1){1'b0}}};
						sar_q <= {1'b1, {(RES_W-1){1'b0}}};
						cnt_q <= 8'(`ADCRT_BIT_CYC - 1);
					end
				end
				adcrt_pkg::ST_CONVERT: begin
					cnt_q <= cnt_q - 8'h01;
					if (step) begin
						cnt_q <= 8'(`ADCRT_BIT_CYC - 1);
						mask_q <= mask_q >> 1;
						sar_q <= kept | (mask_q >> 1);
						if (mask_q[0]) begin
							conv_out.done <= 1'b1;
							conv_out.value <= kept;
							state_q <= adcrt_pkg::ST_SAMPLE;
							cnt_q <= 8'(`ADCRT_SAMPLE_CYC - 1);
						end
					end
				end
				default: state_q <= adcrt_pkg::ST_IDLE;
				endcase
			end
		end
	end
endmodule : adcrt_sar

// ### core/adcrt_cmp.sv
// Threshold compare gating the conversion-done event
`timescale 1ns/1ps
`include "adcrt_regs.svh"
module adcrt_cmp (
	// Inputs
	input wire logic [7:0] upper_in,
	input wire logic [7:0] thresh_in,
	input wire logic enable_in,
	input wire logic polarity_in,
	// Result
	output logic pass_out
);
	// Disabled passes always; polarity picks at-or-above or below
	wire logic at_or_above = (upper_in >= thresh_in);
	assign pass_out = !enable_in || (polarity_in ? !at_or_above : at_or_above);
endmodule : adcrt_cmp

// ### core/adcrt_top.sv
// Converter control registers, threshold compare and result register
// Function
// - Reset clears channel select to input 0
// - Three-bit channel field selects analog input
// - Listed accesses assert a CPU wait cycle
// - Result 16 bits, low six read zero
// - Result loaded from approximation register each end
// - High byte upper eight, low byte two LSBs
// - Reset leaves result register unchanged
// - Mode or channel write may corrupt result
// - Compare enable gates the done interrupt
// - Polarity picks at-or-above or below threshold
// - Threshold compared with upper eight result bits
// - Threshold takes whole-byte writes, resets zero
// - Channel and compare mode take bit writes
// - Compare off: interrupt every conversion
// - Register write restarts running conversion, except a threshold bit write
`timescale 1ns/1ps
`include "adcrt_regs.svh"
module adcrt_top #(
	parameter int RES_W = `ADCRT_RES_W
) (
	// Clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// CPU access
	input wire adcrt_pkg::adcrt_cpu_req_t cpu_req_in,
	input wire logic sub_clk_only_in,
	output logic [15:0] cpu_rdata_out,
	output logic cpu_wait_out,
	// Analog side
	input wire logic cmp_hi_in,
	output logic [2:0] analog_sel_out,
	output logic [RES_W-1:0] dac_trial_out,
	output logic sample_hold_out,
	// Events
	output logic conversion_done_irq_out
);
	// Refuse result widths the lane layout cannot serve
	if (RES_W != 10) begin : g_bad_res_w
		$error("adcrt_top: RES_W must be 10");
	end
	logic [7:0] converter_mode_reg_q;
	logic [7:0] analog_channel_select_q;
	logic [7:0] threshold_compare_mode_q;
	logic [7:0] threshold_value_q;
	logic [RES_W-1:0] result_q;
	logic cmp_sync1_q;
	logic cmp_sync2_q;
	logic [RES_W-1:0] trial_w;
	logic hold_w;
	logic pass_w;
	adcrt_pkg::adcrt_conv_t conv_w;

	// Comparator pin into the clock domain
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cmp_sync1_q <= 1'b0;
			cmp_sync2_q <= 1'b0;
		end else if (ce_in) begin
			cmp_sync1_q <= cmp_hi_in;
			cmp_sync2_q <= cmp_sync1_q;
		end
	end

	// Address decode
	wire logic [15:0] addr = cpu_req_in.addr;
	wire logic hit_mode = (addr == `ADCRT_OFF_MODE);
	wire logic hit_chan = (addr == `ADCRT_OFF_CHAN);
	wire logic hit_cmode = (addr == `ADCRT_OFF_CMP_MODE);
	wire logic hit_thr = (addr == `ADCRT_OFF_THRESH);
	wire logic hit_res = (addr == `ADCRT_OFF_RESULT_LO) || (addr == `ADCRT_OFF_RESULT_HI);
	wire logic wr = cpu_req_in.wr && ce_in;
	wire logic bit_wr = wr && cpu_req_in.bit_op;
	wire logic byte_wr = wr && !cpu_req_in.bit_op;
	wire logic any_cfg_wr = wr && (hit_mode || hit_chan || hit_cmode) || (byte_wr && hit_thr);
	wire logic waited = (wr && (hit_mode || hit_chan || hit_cmode || hit_thr))
		|| (cpu_req_in.rd && ce_in && hit_res);

	// Bit-or-byte write merge, masked to implemented bits
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
		logic [7:0] v;
		v = old;
		if (cpu_req_in.bit_op) v[cpu_req_in.bit_idx] = cpu_req_in.wdata[0];
		else v = cpu_req_in.wdata[7:0];
		return v & mask;
	endfunction : merge

	// Control registers
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			converter_mode_reg_q <= `ADCRT_RST_MODE;
			analog_channel_select_q <= `ADCRT_RST_CHAN;
			threshold_compare_mode_q <= `ADCRT_RST_CMP_MODE;
			threshold_value_q <= `ADCRT_RST_THRESH;
		end else if (ce_in) begin
			if (wr && hit_mode)
				converter_mode_reg_q <= merge(converter_mode_reg_q, `ADCRT_MODE_MASK);
			if (wr && hit_chan)
				analog_channel_select_q <= merge(analog_channel_select_q, `ADCRT_CHAN_MASK);
			if (wr && hit_cmode)
				threshold_compare_mode_q <= merge(threshold_compare_mode_q,
					`ADCRT_CMP_MODE_MASK);
			if (byte_wr && hit_thr)
				threshold_value_q <= cpu_req_in.wdata[7:0];
		end
	end

	// Sequencer, restarted by any configuration write except a bit write to the threshold
	adcrt_sar #(.RES_W(RES_W)) u_sar (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.run_in(converter_mode_reg_q[`ADCRT_BIT_RUN]),
		.restart_in(any_cfg_wr),
		.cmp_hi_in(cmp_sync2_q),
		.conv_out(conv_w),
		.trial_out(trial_w),
		.hold_out(hold_w)
	);

	adcrt_cmp u_cmp (
		.upper_in(conv_w.value[RES_W-1 -: 8]),
		.thresh_in(threshold_value_q),
		.enable_in(threshold_compare_mode_q[`ADCRT_BIT_CMP_EN]),
		.polarity_in(threshold_compare_mode_q[`ADCRT_BIT_CMP_POL]),
		.pass_out(pass_w)
	);

	// Result register, no reset so it holds garbage until first load
	always_ff @(posedge clk_sys_in) begin
		if (ce_in && conv_w.done)
			result_q <= conv_w.value;
	end

	// Read mux and result lane layout
	wire logic [15:0] result_word = {result_q, {`ADCRT_RES_PAD{1'b0}}};
	wire logic [15:0] rd_mux =
		(addr == `ADCRT_OFF_RESULT_LO && cpu_req_in.word) ? result_word :
		(addr == `ADCRT_OFF_RESULT_LO) ? {8'h00, result_word[7:0]} :
		(addr == `ADCRT_OFF_RESULT_HI) ? {8'h00, result_word[15:8]} :
		hit_mode ? {8'h00, converter_mode_reg_q} :
		hit_chan ? {8'h00, analog_channel_select_q} :
		hit_cmode ? {8'h00, threshold_compare_mode_q} :
		hit_thr ? {8'h00, threshold_value_q} : 16'h0000;

	// Registered outputs
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cpu_rdata_out <= 16'h0000;
			cpu_wait_out <= 1'b0;
			analog_sel_out <= 3'h0;
			dac_trial_out <= '0;
			sample_hold_out <= 1'b0;
			conversion_done_irq_out <= 1'b0;
		end else if (ce_in) begin
			cpu_rdata_out <= cpu_req_in.rd ? rd_mux : 16'h0000;
			cpu_wait_out <= waited;
			analog_sel_out <= analog_channel_select_q[2:0];
			dac_trial_out <= trial_w;
			sample_hold_out <= hold_w;
			conversion_done_irq_out <= conv_w.done && pass_w;
		end
	end

	// Checks
	chan_reset_a: assert property (@(posedge clk_sys_in) $rose(arst_n_in)
		|-> analog_channel_select_q == 8'h00) else $error("channel not cleared");
	chan_route_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		ce_in |=> analog_sel_out == $past(analog_channel_select_q[2:0]))
		else $error("channel select not routed");
	wait_gen_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(ce_in && cpu_req_in.wr && hit_thr) |=> cpu_wait_out)
		else $error("no wait cycle on threshold write");
	result_load_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(ce_in && conv_w.done) |=> result_q == $past(conv_w.value))
		else $error("result not loaded");
	irq_plain_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(ce_in && conv_w.done && !threshold_compare_mode_q[7]) |=> conversion_done_irq_out)
		else $error("missing done interrupt");
	irq_above_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(ce_in && conv_w.done && threshold_compare_mode_q[7:6] == 2'b10
		&& conv_w.value[9:2] < threshold_value_q) |=> !conversion_done_irq_out)
		else $error("interrupt below threshold");
	irq_below_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(ce_in && conv_w.done && threshold_compare_mode_q[7:6] == 2'b11
		&& conv_w.value[9:2] < threshold_value_q) |=> conversion_done_irq_out)
		else $error("missing below interrupt");
	thr_bitwr_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(bit_wr && hit_thr) |=> $stable(threshold_value_q))
		else $error("threshold took bit write");
	restart_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(any_cfg_wr && converter_mode_reg_q[7]) |=> !hold_w)
		else $error("conversion not restarted");
endmodule : adcrt_top

// ### testbench/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcrt_regs.svh"
module tb_top;
	logic clk_sys_in;
	logic arst_n_in;
	logic ce_in;
	logic [10:0] frz;
	logic cmp_hi_in;
	adcrt_pkg::adcrt_cpu_req_t cpu_req_in;
	logic [15:0] cpu_rdata_out;
	logic cpu_wait_out;
	logic [2:0] analog_sel_out;
	logic [9:0] dac_trial_out;
	logic sample_hold_out;
	logic conversion_done_irq_out;
	logic [16:0] exp_q[$];
	logic taken_q;
	logic [7:0] d;
	int n_errors;
	int compares;
	int seed;
	int irq_cnt;

	// Device under test
	adcrt_top dut (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.cpu_req_in(cpu_req_in),
		.sub_clk_only_in(1'b0),
		.cpu_rdata_out(cpu_rdata_out),
		.cpu_wait_out(cpu_wait_out),
		.cmp_hi_in(cmp_hi_in),
		.analog_sel_out(analog_sel_out),
		.dac_trial_out(dac_trial_out),
		.sample_hold_out(sample_hold_out),
		.conversion_done_irq_out(conversion_done_irq_out)
	);

	// Clock at 25 MHz
	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	// Compare and count
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Print counts and verdict, then stop
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	// Wait cycles on the driving edge
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : idle

	// One CPU cycle, expected wait and read data noted
	task automatic access(input logic w, input logic b, input logic [2:0] idx,
		input logic [15:0] a, input logic [7:0] wd, input logic wo, input logic [15:0] rexp);
		logic wt;
		wt = w ? (a >= `ADCRT_OFF_MODE && a <= `ADCRT_OFF_THRESH) :
			(a == `ADCRT_OFF_RESULT_LO || a == `ADCRT_OFF_RESULT_HI);
		exp_q.push_back({wt, rexp});
		cpu_req_in <= '{wr: w, rd: ~w, bit_op: b, bit_idx: idx, addr: a,
			wdata: {8'h00, wd}, word: wo};
		@(negedge clk_sys_in);
		cpu_req_in <= '0;
		@(negedge clk_sys_in);
	endtask : access

	task automatic wr(input logic [15:0] a, input logic [7:0] wd);
		access(1'b1, 1'b0, 3'h0, a, wd, 1'b0, 16'h0000);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic wo, input logic [15:0] rexp);
		access(1'b0, 1'b0, 3'h0, a, 8'h00, wo, rexp);
	endtask : rd

	// Note each access taken at the rising edge
	always @(posedge clk_sys_in) taken_q <= cpu_req_in.wr | cpu_req_in.rd;

	// Answer compared with the oldest note
	always @(negedge clk_sys_in) begin
		if (taken_q === 1'b1 && exp_q.size() > 0) begin
			check({cpu_wait_out, cpu_rdata_out}, exp_q.pop_front());
		end
		if (conversion_done_irq_out === 1'b1) begin
			irq_cnt++;
		end
	end

	// One compare setting, interrupts counted, result read back
	task automatic cmp_case(input logic hi, input logic [7:0] threshold_compare_mode, input logic [7:0] thr,
		input logic fire);
		cmp_hi_in <= hi;
		idle(4);
		wr(`ADCRT_OFF_THRESH, thr);
		wr(`ADCRT_OFF_CMP_MODE, threshold_compare_mode);
		idle(2);
		irq_cnt = 0;
		idle(70);
		check(17'(irq_cnt > 0), 17'(fire));
		rd(`ADCRT_OFF_RESULT_LO, 1'b1, {{10{hi}}, 6'h00});
		$display("test compare %h %h done", threshold_compare_mode, thr);
	endtask : cmp_case

	// Watchdog
	initial begin
		#(3000 * 40);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

	// Main sequence
	initial begin
		seed = 32'h74DBCB98;
		cpu_req_in = '0;
		ce_in = 1'b1;
		cmp_hi_in = 1'b1;
		arst_n_in = 1'b0;
		taken_q = 1'b0;
		n_errors = 0;
		compares = 0;
		irq_cnt = 0;
		repeat (16) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		arst_n_in = 1'b1;
		idle(1);
		check(17'(analog_sel_out), 17'h00000);
		rd(`ADCRT_OFF_CHAN, 1'b0, 16'h0000);
		rd(`ADCRT_OFF_CMP_MODE, 1'b0, 16'h0000);
		rd(`ADCRT_OFF_THRESH, 1'b0, 16'h0000);
		rd(16'hFF00, 1'b0, 16'h0000);
		$display("test reset done");
		for (int n = 0; n < 8; n++) begin
			wr(`ADCRT_OFF_CHAN, 8'(n));
			idle(1);
			check(17'(analog_sel_out), 17'(n));
			rd(`ADCRT_OFF_CHAN, 1'b0, 16'(n));
		end
		$display("test channel done");
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			wr(`ADCRT_OFF_THRESH, d);
			rd(`ADCRT_OFF_THRESH, 1'b0, {8'h00, d});
		end
		wr(`ADCRT_OFF_CHAN, 8'h00);
		access(1'b1, 1'b1, 3'h2, `ADCRT_OFF_CHAN, 8'h01, 1'b0, 16'h0000);
		rd(`ADCRT_OFF_CHAN, 1'b0, 16'h0004);
		access(1'b1, 1'b1, 3'h7, `ADCRT_OFF_CMP_MODE, 8'h01, 1'b0, 16'h0000);
		rd(`ADCRT_OFF_CMP_MODE, 1'b0, 16'h0080);
		access(1'b1, 1'b1, 3'h0, `ADCRT_OFF_THRESH, {7'h00, ~d[0]}, 1'b0, 16'h0000);
		rd(`ADCRT_OFF_THRESH, 1'b0, {8'h00, d});
		$display("test register access done");
		wr(`ADCRT_OFF_CMP_MODE, 8'h00);
		wr(`ADCRT_OFF_MODE, 8'h80);
		irq_cnt = 0;
		idle(70);
		check(17'(irq_cnt > 1), 17'h00001);
		rd(`ADCRT_OFF_RESULT_LO, 1'b1, 16'hFFC0);
		rd(`ADCRT_OFF_RESULT_HI, 1'b0, 16'h00FF);
		rd(`ADCRT_OFF_RESULT_LO, 1'b0, 16'h00C0);
		$display("test conversion done");
		// Clock enable low must freeze the running conversion
		ce_in <= 1'b0;
		idle(1);
		frz = {sample_hold_out, dac_trial_out};
		idle(10);
		check({6'h00, sample_hold_out, dac_trial_out}, {6'h00, frz});
		ce_in <= 1'b1;
		$display("test freeze done");
		// Run bit cleared stops conversions and their interrupts
		wr(`ADCRT_OFF_MODE, 8'h00);
		idle(2);
		irq_cnt = 0;
		idle(40);
		check(17'(irq_cnt), 17'h00000);
		check(17'(sample_hold_out), 17'h00000);
		wr(`ADCRT_OFF_MODE, 8'h80);
		$display("test stop done");
		wr(`ADCRT_OFF_CHAN, 8'h03);
		idle(2);
		irq_cnt = 0;
		repeat (8) begin
			wr(`ADCRT_OFF_CHAN, 8'h03);
			check(17'(sample_hold_out), 17'h00000);
			idle(10);
			check({6'h00, sample_hold_out, dac_trial_out}, {7'h01, 10'h3C0});
		end
		check(17'(irq_cnt), 17'h00000);
		$display("test restart done");
		cmp_case(1'b0, 8'h80, 8'h01, 1'b0);
		cmp_case(1'b0, 8'h80, 8'h00, 1'b1);
		cmp_case(1'b0, 8'hC0, 8'h00, 1'b0);
		cmp_case(1'b0, 8'hC0, 8'h01, 1'b1);
		cmp_case(1'b1, 8'hC0, 8'hFF, 1'b0);
		cmp_case(1'b1, 8'h80, 8'hFF, 1'b1);
		conclude();
	end
endmodule : tb_top
